// ==== rtl/can_filter_pkg.sv ====
// types shared by the acceptance filter files
package can_filter_pkg;
    typedef logic [31:0] id_word_t;
    typedef enum logic [0:0] {BUS_IDLE, BUS_ANSWER} bus_state_t;
endpackage

// ==== rtl/can_filter_regs.svh ====
// register offsets, field positions and reset values of the acceptance filter
//
// Contract
// [R1] each receive mailbox compares id under its mask
// [R2] mask bit 0 ignores, 1 compares id bit
// [R3] one judge bit: 0 discard, 1 receive
// [R4] compare covers rtr and ide bits too
// [R5] ide compared only in mixed format 10b
// [R6] software writes ide 0 outside mixed format
// [R7] mask invalid bit disables mask, not for fifo
// [R8] fifo uses last two masks, two filters
// [R9] fifo compares against two fifo id registers
// [R10] received id loads the lookup support register
// [R11] support reads upper eight bits plus one-hot
// [R12] software table of 256 bytes decides acceptance
// [R13] lookup decode covers standard identifiers only
// [R14] standard 11-bit and extended 29-bit identifiers
// [R15] accept when all masked bits equal stored bits
`ifndef CAN_FILTER_REGS_SVH
`define CAN_FILTER_REGS_SVH

// ***********************************************************
// word offsets (byte address = 4 * index)
// ***********************************************************
`define CF_CTRL_IDX        8'h00
`define CF_INVALID_IDX     8'h01
`define CF_SUPPORT_IDX     8'h02
`define CF_FIFO_A_IDX      8'h03
`define CF_FIFO_B_IDX      8'h04
`define CF_STATUS_IDX      8'h05
`define CF_MASK_BASE_IDX   8'h10
`define CF_MBOX_BASE_IDX   8'h20

// ***********************************************************
// id word layout: [31] ide, [30] rtr, [28:18] sid, [17:0] eid
// ***********************************************************
`define CF_IDE_BIT         31
`define CF_RTR_BIT         30
`define CF_SID_HI          28
`define CF_SID_LO          18
`define CF_SID_UP_LO       21
`define CF_SID_DN_HI       20
`define CF_ID_USED         32'hDFFFFFFF

// control word fields
`define CF_FMT_HI          1
`define CF_FMT_LO          0
`define CF_FIFO_BIT        2
`define CF_FMT_MIXED       2'h2

// support word fields: [7:0] one-hot, [15:8] index
`define CF_SUP_IDX_LO      8
`define CF_SUP_IDX_HI      15

`define CF_ZERO32          32'h00000000

`endif

// ==== rtl/can_receive_acceptance_filter.sv ====
// receive acceptance filter with avalon-mm register slave
//
// Added by the designer: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ns
`include "can_filter_regs.svh"
module can_receive_acceptance_filter #(
    parameter int MBOX  = 32,
    parameter int MASKS = 8,
    parameter int MBW   = 5
) (
    // clock and reset
    input  wire logic           mclk_i,
    input  wire logic           rst_i,
    // avalon-mm slave
    input  wire logic [7:0]     avs_address_i,
    input  wire logic           avs_read_i,
    input  wire logic           avs_write_i,
    input  wire logic [31:0]    avs_writedata_i,
    input  wire logic [3:0]     avs_byteenable_i,
    output logic      [31:0]    avs_readdata_o,
    output logic                avs_waitrequest_o,
    // received frame from protocol engine
    input  wire logic           rx_valid_i,
    input  wire logic [31:0]    rx_id_i,
    input  wire logic [MBW-1:0] rx_mbox_i,
    // acceptance result
    output logic                judge_valid_o,
    output logic                judge_o,
    output logic [MBW-1:0]      judge_mbox_o
);
    // ***********************************************************
    // functions
    // ***********************************************************
    // masked compare; ide dropped unless mixed format
    function automatic logic id_match(input logic [31:0] rx, input logic [31:0] ref_id,
                                      input logic [31:0] mask, input logic mixed);
        logic [31:0] sel;
        sel = mask & `CF_ID_USED;                             // see [R4] see [R14]
        sel[`CF_IDE_BIT] = mask[`CF_IDE_BIT] & mixed;         // see [R5]
        return ((rx ^ ref_id) & sel) == `CF_ZERO32;           // see [R2] see [R15]
    endfunction

    function automatic logic [31:0] merge_be(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (be[b])
            begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // ***********************************************************
    // register state
    // ***********************************************************
    logic [31:0]      ctrl_ff,    nxt_ctrl;
    logic [MBOX-1:0]  invalid_ff, nxt_invalid;
    logic [31:0]      fifo_a_ff,  nxt_fifo_a;
    logic [31:0]      fifo_b_ff,  nxt_fifo_b;
    logic [10:0]      support_ff, nxt_support;
    logic [31:0]      mask_ff [MASKS];
    logic [31:0]      nxt_mask [MASKS];
    logic [31:0]      accept_cnt_ff, nxt_accept_cnt;

    can_filter_pkg::bus_state_t bus_ff, nxt_bus;
    logic [31:0]      rdata_ff, nxt_rdata;

    logic             mixed;
    logic             fifo_mode;
    logic             wr_hit;
    logic             mbox_wr;
    logic [31:0]      mbox_rd;

    assign mixed     = ctrl_ff[`CF_FMT_HI:`CF_FMT_LO] == `CF_FMT_MIXED;
    assign fifo_mode = ctrl_ff[`CF_FIFO_BIT];
    // writes land on the edge that completes the request, never while waitrequest is high
    assign wr_hit    = avs_write_i && bus_ff == can_filter_pkg::BUS_ANSWER;
    assign mbox_wr   = wr_hit && avs_address_i[7:MBW] == `CF_MBOX_BASE_IDX >> MBW;

    // ***********************************************************
    // receive pipeline: stage 1 reads mailbox id, stage 2 judges
    // ***********************************************************
    logic             st1_ff, nxt_st1;
    logic [31:0]      st1_id_ff, nxt_st1_id;
    logic [MBW-1:0]   st1_mbox_ff, nxt_st1_mbox;
    logic             jv_ff, nxt_jv;
    logic             jd_ff, nxt_jd;
    logic [MBW-1:0]   jm_ff, nxt_jm;

    // mailbox ids; a bus write in the cycle of a lookup uses the old id
    id_store_mem #(
        .DEPTH (MBOX),
        .AW    (MBW)
    ) u_ids (
        .mclk_i    (mclk_i),
        .wr_en_i   (mbox_wr),
        .wr_addr_i (avs_address_i[MBW-1:0]),
        .wr_data_i (avs_writedata_i),
        .rd_addr_i (rx_mbox_i),
        .rd_data_o (mbox_rd)
    );

    always_comb
    begin
        logic [31:0] mk;
        logic        hit_a;
        logic        hit_b;
        mk           = mask_ff[st1_mbox_ff[2:0]];
        hit_a = id_match(st1_id_ff, fifo_a_ff, mask_ff[MASKS-2], mixed);  // see [R9]
        hit_b = id_match(st1_id_ff, fifo_b_ff, mask_ff[MASKS-1], mixed);  // see [R8]
        nxt_st1      = rx_valid_i;
        nxt_st1_id   = rx_valid_i ? rx_id_i : st1_id_ff;
        nxt_st1_mbox = rx_valid_i ? rx_mbox_i : st1_mbox_ff;
        nxt_jv       = st1_ff;
        nxt_jm       = st1_ff ? st1_mbox_ff : jm_ff;
        nxt_jd       = jd_ff;
        if (st1_ff)
        begin
            if (fifo_mode)
            begin
                nxt_jd = hit_a | hit_b;                        // see [R8] see [R7]
            end
            else if (invalid_ff[st1_mbox_ff])
            begin
                // see [R7]
                nxt_jd = id_match(st1_id_ff, mbox_rd, `CF_ZERO32 - 32'h00000001, mixed);
            end
            else
            begin
                nxt_jd = id_match(st1_id_ff, mbox_rd, mk, mixed);  // see [R1]
            end
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            st1_ff      <= 1'b0;
            st1_id_ff   <= `CF_ZERO32;
            st1_mbox_ff <= '0;
            jv_ff       <= 1'b0;
            jd_ff       <= 1'b0;
            jm_ff       <= '0;
        end
        else
        begin
            st1_ff      <= nxt_st1;
            st1_id_ff   <= nxt_st1_id;
            st1_mbox_ff <= nxt_st1_mbox;
            jv_ff       <= nxt_jv;
            jd_ff       <= nxt_jd;
            jm_ff       <= nxt_jm;
        end
    end

    assign judge_valid_o = jv_ff;
    assign judge_o       = jd_ff;                              // see [R3]
    assign judge_mbox_o  = jm_ff;

    // ***********************************************************
    // register writes and hardware updates
    // ***********************************************************
    always_comb
    begin
        nxt_ctrl       = ctrl_ff;
        nxt_invalid    = invalid_ff;
        nxt_fifo_a     = fifo_a_ff;
        nxt_fifo_b     = fifo_b_ff;
        nxt_support    = support_ff;
        nxt_accept_cnt = accept_cnt_ff + {31'h0, jv_ff & jd_ff};
        for (int k = 0; k < MASKS; k++)
        begin
            nxt_mask[k] = mask_ff[k];
        end
        if (wr_hit)
        begin
            if (avs_address_i == `CF_CTRL_IDX)
            begin
                nxt_ctrl = merge_be(ctrl_ff, avs_writedata_i, avs_byteenable_i);
            end
            if (avs_address_i == `CF_INVALID_IDX)
            begin
                nxt_invalid = merge_be(invalid_ff, avs_writedata_i, avs_byteenable_i);
            end
            if (avs_address_i == `CF_FIFO_A_IDX)
            begin
                nxt_fifo_a = merge_be(fifo_a_ff, avs_writedata_i, avs_byteenable_i);
            end
            if (avs_address_i == `CF_FIFO_B_IDX)
            begin
                nxt_fifo_b = merge_be(fifo_b_ff, avs_writedata_i, avs_byteenable_i);
            end
            for (int k = 0; k < MASKS; k++)
            begin
                if (avs_address_i == `CF_MASK_BASE_IDX + 8'(k))
                begin
                    nxt_mask[k] = merge_be(mask_ff[k], avs_writedata_i, avs_byteenable_i);
                end
            end
        end
        // support word is loaded by hardware only; no bus write reaches it
        if (rx_valid_i)
        begin
            nxt_support = rx_id_i[`CF_SID_HI:`CF_SID_LO];      // see [R10] see [R13]
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            ctrl_ff       <= `CF_ZERO32;
            invalid_ff    <= '0;
            fifo_a_ff     <= `CF_ZERO32;
            fifo_b_ff     <= `CF_ZERO32;
            support_ff    <= 11'h000;
            accept_cnt_ff <= `CF_ZERO32;
            for (int k = 0; k < MASKS; k++)
            begin
                mask_ff[k] <= `CF_ZERO32;
            end
        end
        else
        begin
            ctrl_ff       <= nxt_ctrl;
            invalid_ff    <= nxt_invalid;
            fifo_a_ff     <= nxt_fifo_a;
            fifo_b_ff     <= nxt_fifo_b;
            support_ff    <= nxt_support;
            accept_cnt_ff <= nxt_accept_cnt;
            for (int k = 0; k < MASKS; k++)
            begin
                mask_ff[k] <= nxt_mask[k];
            end
        end
    end

    // ***********************************************************
    // avalon read path: one wait cycle, data registered
    // ***********************************************************
    always_comb
    begin
        nxt_bus   = can_filter_pkg::BUS_IDLE;
        nxt_rdata = rdata_ff;
        if (bus_ff == can_filter_pkg::BUS_IDLE && (avs_read_i || avs_write_i))
        begin
            nxt_bus   = can_filter_pkg::BUS_ANSWER;
            nxt_rdata = `CF_ZERO32;
            unique case (avs_address_i)
                `CF_CTRL_IDX:    nxt_rdata = ctrl_ff;
                `CF_INVALID_IDX: nxt_rdata = 32'(invalid_ff);
                `CF_FIFO_A_IDX:  nxt_rdata = fifo_a_ff;
                `CF_FIFO_B_IDX:  nxt_rdata = fifo_b_ff;
                `CF_STATUS_IDX:  nxt_rdata = accept_cnt_ff;
                `CF_SUPPORT_IDX:
                begin
                    nxt_rdata[`CF_SUP_IDX_HI:`CF_SUP_IDX_LO] = support_ff[10:3]; // see [R11]
                    nxt_rdata[7:0] = 8'h01 << support_ff[2:0];                   // see [R11]
                end
                default:
                begin
                    for (int k = 0; k < MASKS; k++)
                    begin
                        if (avs_address_i == `CF_MASK_BASE_IDX + 8'(k))
                        begin
                            nxt_rdata = mask_ff[k];
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            bus_ff   <= can_filter_pkg::BUS_IDLE;
            rdata_ff <= `CF_ZERO32;
        end
        else
        begin
            bus_ff   <= nxt_bus;
            rdata_ff <= nxt_rdata;
        end
    end

    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && bus_ff == can_filter_pkg::BUS_IDLE;
    assign avs_readdata_o    = rdata_ff;

    // ***********************************************************
    // assertions
    // ***********************************************************
    judge_follows_rx_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see [R3]
        rx_valid_i |-> ##2 judge_valid_o)
        else $error("judge not two cycles after frame");

    support_load_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see [R10]
        rx_valid_i |=> support_ff == $past(rx_id_i[`CF_SID_HI:`CF_SID_LO]))
        else $error("support register not loaded");

    support_onehot_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see [R11]
        (bus_ff == can_filter_pkg::BUS_ANSWER && $past(avs_address_i) == `CF_SUPPORT_IDX
         && $past(avs_read_i)) |-> $onehot(avs_readdata_o[7:0]))
        else $error("support decode not one-hot");

    fifo_zero_mask_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see [R8]
        (st1_ff && fifo_mode && mask_ff[MASKS-1] == `CF_ZERO32) |=> judge_o)
        else $error("open fifo filter rejected frame");

    exact_match_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see [R15]
        (st1_ff && !fifo_mode && !invalid_ff[st1_mbox_ff] && st1_id_ff == mbox_rd) |=> judge_o)
        else $error("identical id rejected");

    mask_off_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see [R7]
        (st1_ff && !fifo_mode && invalid_ff[st1_mbox_ff]
         && ((st1_id_ff ^ mbox_rd) & `CF_ID_USED & 32'h7FFFFFFF) != `CF_ZERO32) |=> !judge_o)
        else $error("unmasked mailbox accepted a mismatch");

    ide_ignored_a: assert property (@(posedge mclk_i) disable iff (rst_i) // see [R5]
        (st1_ff && !fifo_mode && !mixed && !invalid_ff[st1_mbox_ff]
         && (st1_id_ff ^ mbox_rd) == 32'h80000000) |=> judge_o)
        else $error("ide compared outside mixed format");

    wait_one_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (avs_read_i && avs_waitrequest_o) |=> !avs_waitrequest_o)
        else $error("waitrequest held beyond one cycle");
endmodule

// ==== rtl/id_store_mem.sv ====
// register-read memory holding mailbox ids
`timescale 1ns/1ns
module id_store_mem #(
    parameter int DEPTH = 32,
    parameter int AW    = 5
) (
    // clock
    input  wire logic          mclk_i,
    // write port
    input  wire logic          wr_en_i,
    input  wire logic [AW-1:0] wr_addr_i,
    input  wire logic [31:0]   wr_data_i,
    // read port
    input  wire logic [AW-1:0] rd_addr_i,
    output logic      [31:0]   rd_data_o
);
    logic [31:0] mem_ff [DEPTH];
    logic [31:0] rd_ff;

    always_ff @(posedge mclk_i)
    begin
        if (wr_en_i)
        begin
            mem_ff[wr_addr_i] <= wr_data_i;
        end
        rd_ff <= mem_ff[rd_addr_i];
    end

    assign rd_data_o = rd_ff;
endmodule

// ==== tb/can_engine_model.sv ====
// behavioural protocol engine that hands received identifiers to the filter
`timescale 1ns/1ns
module can_engine_model (
    // clock
    input  wire logic        mclk_i,
    // received frame out
    output logic             rx_valid_o,
    output logic [31:0]      rx_id_o,
    output logic [4:0]       rx_mbox_o
);
    initial
    begin
        rx_valid_o = 1'b0;
        rx_id_o    = 32'h00000000;
        rx_mbox_o  = 5'h00;
    end

    // gap 0 leaves valid up, so a following send lands in the very next cycle
    task automatic send(input logic [31:0] id, input logic [4:0] mb, input int gap);
        @(posedge mclk_i);
        rx_valid_o <= 1'b1;
        rx_id_o    <= id;
        rx_mbox_o  <= mb;
        repeat (gap)
        begin
            @(posedge mclk_i);
            rx_valid_o <= 1'b0;
            rx_id_o    <= ~id;
            rx_mbox_o  <= ~mb;
        end
    endtask

    // released lines show the inverse so a stale id can never pass for a fresh one
    task automatic idle();
        @(posedge mclk_i);
        rx_valid_o <= 1'b0;
        rx_id_o    <= ~rx_id_o;
        rx_mbox_o  <= ~rx_mbox_o;
    endtask
endmodule

// ==== tb/tb_top.sv ====
// self-checking bench for the receive acceptance filter
`timescale 1ns/1ns
`include "can_filter_regs.svh"
module tb_top;
    typedef struct packed {logic j; logic [4:0] mb;} note_t;
    logic        mclk_i, rst_i, avs_read_i, avs_write_i, rx_valid;
    logic [7:0]  avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, rx_id;
    logic [3:0]  avs_byteenable_i;
    logic        avs_waitrequest_o, judge_valid_o, judge_o;
    logic [4:0]  rx_mbox, judge_mbox_o, m;
    logic [31:0] ctrl, inv, fa, fb, acc, id;
    logic [31:0] mk [8];
    logic [31:0] mbx [32];
    logic [31:0] sup_ids [6];
    note_t       jq [$];
    logic [31:0] rq [$];
    int          stq [$];
    int          num_errors, total_checks, cyc, i;
    integer      seed;

    can_receive_acceptance_filter dut (.mclk_i(mclk_i), .rst_i(rst_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .rx_valid_i(rx_valid), .rx_id_i(rx_id), .rx_mbox_i(rx_mbox),
        .judge_valid_o(judge_valid_o), .judge_o(judge_o), .judge_mbox_o(judge_mbox_o));
    can_engine_model eng (.mclk_i(mclk_i), .rx_valid_o(rx_valid), .rx_id_o(rx_id),
        .rx_mbox_o(rx_mbox));

    initial
    begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) cyc <= cyc + 1;

    function automatic logic [31:0] sidw(input logic [10:0] s);
        return {3'b000, s, 18'h00000};
    endfunction
    function automatic logic [31:0] sup(input logic [31:0] w);
        return {16'h0000, w[28:21], 8'h01 << w[20:18]};
    endfunction
    // ide takes part only in mixed format; fifo mode ignores mailbox ids and mask-invalid
    function automatic logic exp_j(input logic [31:0] w, input logic [4:0] mb);
        logic [31:0] u;
        u = `CF_ID_USED;
        if (ctrl[1:0] != `CF_FMT_MIXED) u[31] = 1'b0;
        if (ctrl[2]) return (((w ^ fa) & mk[6] & u) == 0) || (((w ^ fb) & mk[7] & u) == 0);
        if (inv[mb]) return ((w ^ mbx[mb]) & u) == 0;
        return ((w ^ mbx[mb]) & mk[mb[2:0]] & u) == 0;
    endfunction

    task automatic fail(input string n, input logic [31:0] e, input logic [31:0] g);
        num_errors++;
        $display("[FAIL] %s expected %h seen %h", n, e, g);
    endtask
    task automatic chk_judge(input note_t n, input int st);
        total_checks += 3;
        if (judge_o !== n.j) fail("judge", n.j, judge_o);
        if (judge_mbox_o !== n.mb) fail("judge_mbox", n.mb, judge_mbox_o);
        if (cyc - st != 2) fail("judge_latency", 2, cyc - st);
    endtask
    task automatic chk_read(input logic [31:0] e);
        total_checks++;
        if (avs_readdata_o !== e) fail("readdata", e, avs_readdata_o);
    endtask

    // watcher: results are settled at the falling edge of their cycle
    always @(negedge mclk_i)
    begin
        if (rst_i === 1'b0)
        begin
            if (rx_valid === 1'b1) stq.push_back(cyc);
            if (judge_valid_o === 1'b1)
            begin
                if (jq.size() == 0 || stq.size() == 0) fail("judge_valid", 0, 1);
                else chk_judge(jq.pop_front(), stq.pop_front());
            end
            if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0)
            begin
                if (rq.size() == 0) fail("read_note", 0, 1);
                else chk_read(rq.pop_front());
            end
        end
    end

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        int n;
        @(posedge mclk_i);
        avs_address_i    <= a;
        avs_write_i      <= w;
        avs_read_i       <= ~w;
        avs_writedata_i  <= d;
        avs_byteenable_i <= be;
        n = 0;
        do
        begin
            @(negedge mclk_i);
            n++;
        end
        while (avs_waitrequest_o !== 1'b0 && n < 50);
        if (n >= 50) fail("waitrequest", 0, 1);
        @(posedge mclk_i);
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        if (a == `CF_CTRL_IDX) ctrl = d;
        else if (a == `CF_INVALID_IDX) inv = d;
        else if (a == `CF_FIFO_A_IDX) fa = d;
        else if (a == `CF_FIFO_B_IDX) fb = d;
        else if (a[7:3] == 5'h02) mk[a[2:0]] = d;
        else if (a[7:5] == 3'h1) mbx[a[4:0]] = d;
        bus(1'b1, a, d, 4'hF);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rq.push_back(e);
        bus(1'b0, a, 32'h00000000, 4'hF);
    endtask
    task automatic frame(input logic [31:0] w, input logic [4:0] mb, input int gap);
        note_t n;
        n.j  = exp_j(w, mb);
        n.mb = mb;
        if (n.j) acc++;
        jq.push_back(n);
        eng.send(w, mb, gap);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge mclk_i);
        fail("watchdog", 0, 1);
        conclude();
    end

    initial
    begin
        {avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = '0;
        {ctrl, inv, fa, fb, acc, cyc, num_errors, total_checks} = '0;
        avs_byteenable_i = 4'h0;
        mk   = '{default: 32'h00000000};
        mbx  = '{default: 32'h00000000};
        seed = 32'h9C4E8A5E;
        rst_i = 1'b1;
        repeat (16) @(posedge mclk_i);
        rst_i <= 1'b0;
        // all readable words reset to zero, but an idle support word decodes sid 0 to bit 0
        foreach (sup_ids[k]) rd(k[7:0], (k == `CF_SUPPORT_IDX) ? 32'h00000001 : 32'h00000000);
        wr(8'h08, 32'hFFFFFFFF);
        rd(8'h08, 32'h00000000); // unmapped word
        wr(`CF_MBOX_BASE_IDX, sidw(11'h123));
        rd(`CF_MBOX_BASE_IDX, 32'h00000000); // mailbox ids are write only
        $display("test reset_map done");
        wr(`CF_MASK_BASE_IDX, 32'hFFFFFFFF);
        frame(sidw(11'h123), 5'h00, 1);
        frame(sidw(11'h124), 5'h00, 1);
        frame(sidw(11'h123) | 32'h40000000, 5'h00, 1);
        frame(sidw(11'h123) | 32'h20000000, 5'h00, 1);
        wr(`CF_MASK_BASE_IDX, 32'hFFFBFFFF);
        for (i = 0; i < 4; i++) frame(sidw(11'h120 + 11'(i)), 5'h00, i % 2);
        eng.idle();
        $display("test mailbox_mask done");
        wr(`CF_MASK_BASE_IDX, 32'hFFFFFFFF);
        for (i = 0; i < 4; i++)
        begin
            wr(`CF_CTRL_IDX, i);
            frame(sidw(11'h123) | 32'h80000000, 5'h00, 1);
        end
        // a stored ide of 1 is only legal under mixed format
        wr(`CF_CTRL_IDX, 32'h00000002);
        wr(`CF_MASK_BASE_IDX + 8'h01, 32'hFFFFFFFF);
        wr(`CF_MBOX_BASE_IDX + 8'h01, {3'b100, 29'h12345678});
        frame({3'b100, 29'h12345678}, 5'h01, 1);
        frame({3'b100, 29'h12345679}, 5'h01, 1);
        frame({3'b110, 29'h12345678}, 5'h01, 1);
        $display("test id_format done");
        wr(`CF_CTRL_IDX, 32'h00000000);
        wr(`CF_MBOX_BASE_IDX + 8'h02, sidw(11'h7FF));
        frame(sidw(11'h000), 5'h02, 1);
        wr(`CF_INVALID_IDX, 32'h00000004);
        frame(sidw(11'h000), 5'h02, 1);
        frame(sidw(11'h7FF), 5'h02, 1);
        $display("test mask_invalid done");
        wr(`CF_FIFO_A_IDX, 32'h11223344);
        bus(1'b1, `CF_FIFO_A_IDX, 32'hAABBCCDD, 4'h5);
        rd(`CF_FIFO_A_IDX, 32'h11BB33DD); // byte lanes merge
        wr(`CF_CTRL_IDX, 32'h00000004);
        wr(`CF_MASK_BASE_IDX + 8'h06, 32'hFFFFFFFF);
        wr(`CF_MASK_BASE_IDX + 8'h07, 32'hFFF3FFFF);
        wr(`CF_FIFO_A_IDX, sidw(11'h100));
        wr(`CF_FIFO_B_IDX, sidw(11'h204));
        wr(`CF_MBOX_BASE_IDX + 8'h03, sidw(11'h555));
        frame(sidw(11'h100), 5'h03, 0);
        frame(sidw(11'h207), 5'h03, 0);
        frame(sidw(11'h101), 5'h03, 0);
        frame(sidw(11'h555), 5'h03, 0);
        frame(sidw(11'h101), 5'h02, 1);
        // a fully open second filter takes any id
        wr(`CF_MASK_BASE_IDX + 8'h07, 32'h00000000);
        frame(sidw(11'h3AB), 5'h03, 1);
        $display("test fifo_filter done");
        wr(`CF_CTRL_IDX, 32'h00000000);
        sup_ids = '{sidw(11'h000), sidw(11'h00D), sidw(11'h6F3), sidw(11'h6F4),
                    sidw(11'h6FF), {3'b100, 29'h12345678}};
        foreach (sup_ids[k])
        begin
            frame(sup_ids[k], 5'h00, 1);
            rd(`CF_SUPPORT_IDX, sup(sup_ids[k]));
        end
        $display("test lookup_support done");
        wr(`CF_CTRL_IDX, $random(seed) & 32'h00000003);
        for (i = 0; i < 8; i++) wr(`CF_MASK_BASE_IDX + 8'(i), $random(seed));
        for (i = 0; i < 32; i++)
        begin
            id = $random(seed);
            if (ctrl[1:0] != `CF_FMT_MIXED) id[31] = 1'b0;
            wr(`CF_MBOX_BASE_IDX + 8'(i), id);
        end
        for (i = 0; i < 40; i++)
        begin
            m  = $random(seed);
            id = mbx[m] ^ (($random(seed) & 1) ? 32'h00000000 : 32'h00000001 << (i % 32));
            frame(id, m, $random(seed) & 1);
        end
        eng.idle();
        repeat (4) @(posedge mclk_i);
        rd(`CF_STATUS_IDX, acc);
        total_checks++;
        if (jq.size() != 0) fail("pending_judges", 0, jq.size());
        $display("test random_burst done");
        conclude();
    end
endmodule
